//--- core/spx_indexer.v
// shortest-rotation indexer command selection, start handshake and apb registers
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "spx_consts.vh"

module spx_indexer #(
  parameter TICK_CYCLES = `SPX_TICK_NS / `SPX_CLK_NS,
  parameter SPEED_W     = 16
) (
  // clock and reset
  input  wire                pclk,
  input  wire                presetn,
  // apb slave
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [7:0]          paddr,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  // fieldbus bit devices
  input  wire                start_request,
  input  wire                op_mode_sel_1,
  input  wire                op_mode_sel_2,
  input  wire                pos_speed_spec_select,
  input  wire                next_station_sel_bit1,
  input  wire                next_station_sel_bit2,
  input  wire                next_station_sel_bit3,
  input  wire                next_station_sel_bit4,
  input  wire                next_station_sel_bit5,
  input  wire                next_station_sel_bit6,
  input  wire                next_station_sel_bit7,
  input  wire                next_station_sel_bit8,
  input  wire                speed_sel_bit1,
  input  wire                speed_sel_bit2,
  input  wire                speed_sel_bit3,
  // fieldbus word registers
  input  wire [15:0]         next_station_word,
  input  wire [SPEED_W-1:0]  table_or_speed_word,
  // motion core status, same clock
  input  wire                home_done,
  input  wire                pos_in_range,
  input  wire [7:0]          cur_station,
  input  wire                motion_done,
  // motion command
  output reg                 move_start,
  output reg  [7:0]          move_station,
  output reg  [2:0]          move_table,
  output reg                 move_use_speed,
  output reg  [SPEED_W-1:0]  move_speed,
  output reg                 move_dir_ccw,
  // fieldbus answers and torque
  output reg                 in_position_flag,
  output reg                 movement_complete_flag,
  output reg                 home_incomplete_alarm,
  output reg                 next_station_warning,
  output reg                 torque_standstill,
  output reg  [15:0]         torque_limit_value,
  // interrupt
  output reg                 irq
);

  localparam SYNC_W = 31 + SPEED_W;
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_MOVE = 2'b10;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // station is legal if not above division count minus one
  function stn_ok;
    input [7:0] stn;
    input [7:0] div;
    begin
      stn_ok = ({1'b0, stn} < {1'b0, div}); // RULE6
    end
  endfunction

  // ----------------------------------------
  // input synchroniser
  // ----------------------------------------
  wire [SYNC_W-1:0] raw_in;
  reg  [SYNC_W-1:0] sync1_reg;
  reg  [SYNC_W-1:0] sync2_reg;

  assign raw_in = {start_request, op_mode_sel_1, op_mode_sel_2, pos_speed_spec_select,
                   next_station_sel_bit8, next_station_sel_bit7, next_station_sel_bit6,
                   next_station_sel_bit5, next_station_sel_bit4, next_station_sel_bit3,
                   next_station_sel_bit2, next_station_sel_bit1,
                   speed_sel_bit3, speed_sel_bit2, speed_sel_bit1,
                   next_station_word, table_or_speed_word};

  // two flops before any logic looks at the fieldbus inputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= {SYNC_W{1'b0}};
      sync2_reg <= {SYNC_W{1'b0}};
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  wire               s_start = sync2_reg[SYNC_W-1];
  wire               s_md0   = sync2_reg[SYNC_W-2];
  wire               s_md1   = sync2_reg[SYNC_W-3];
  wire               s_spec  = sync2_reg[SYNC_W-4];
  wire [7:0]         s_bits  = sync2_reg[SYNC_W-5:SYNC_W-12];
  wire [2:0]         s_spd   = sync2_reg[SYNC_W-13:SYNC_W-15];
  wire [15:0]        s_nsw   = sync2_reg[SPEED_W+15:SPEED_W];
  wire [SPEED_W-1:0] s_tsw   = sync2_reg[SPEED_W-1:0];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [3:0]  ctrl_reg;
  reg [7:0]  div_reg;
  reg [15:0] tq_reg;
  reg [15:0] dly_reg;
  reg [3:0]  stat_reg;
  reg [3:0]  en_reg;
  reg [1:0]  state_reg;
  reg        start_d_reg;
  reg        pwr_chk_reg;
  reg [15:0] dly_cnt_reg;
  reg [31:0] tick_cnt_reg;
  reg        inpos_d_reg;

  wire acc      = psel & penable & pready;
  wire wr       = acc & pwrite;
  wire two_stn  = ctrl_reg[`SPX_CTRL_TWO];
  wire idle     = (state_reg == ST_IDLE);

  // mode active only with indexer chosen and both mode bits on
  wire mode_on  = ctrl_reg[`SPX_CTRL_IDX] & s_md0 & s_md1; // RULE13
  wire start_rq = mode_on & s_start & ~start_d_reg;

  // ----------------------------------------
  // command selection
  // ----------------------------------------
  reg [7:0]         sel_station;
  reg [2:0]         sel_table;
  reg               sel_use_spd;
  reg               sel_ok;
  reg [8:0]         fwd_dist;
  reg               sel_ccw;

  // station, table and speed source from bits or words
  always @* begin
    sel_use_spd = 1'b0;
    sel_ok      = 1'b1;
    if (s_spec) begin
      sel_station = s_nsw[7:0]; // RULE14
      if (s_nsw[15:8] != 8'h00) begin
        sel_ok = 1'b0;
      end
      if (ctrl_reg[`SPX_CTRL_SPD] && two_stn) begin
        sel_use_spd = 1'b1; // RULE15 RULE16
        sel_table   = `SPX_TBL_FIRST;
      end else begin
        // table number one to seven from the speed word
        sel_table = s_tsw[2:0] - 3'h1; // RULE17
        if (s_tsw < `SPX_TBL_MINREG || s_tsw > `SPX_TBL_MAXREG) begin
          sel_ok = 1'b0;
        end
      end
    end else begin
      sel_station = s_bits; // RULE1
      if (two_stn) begin
        sel_table = s_spd; // RULE2
      end else begin
        sel_table = `SPX_TBL_FIRST; // RULE3
      end
    end
    if (!stn_ok(sel_station, div_reg)) begin
      sel_ok = 1'b0;
    end
  end

  // forward distance modulo division count decides the shorter way
  always @* begin
    if (sel_station >= cur_station) begin
      fwd_dist = {1'b0, sel_station} - {1'b0, cur_station};
    end else begin
      fwd_dist = {1'b0, sel_station} + {1'b0, div_reg} - {1'b0, cur_station};
    end
    // direction setting is not consulted here
    sel_ccw = (fwd_dist > {1'b0, div_reg} - fwd_dist); // RULE18 RULE12
  end

  wire go      = start_rq & idle & home_done & sel_ok & movement_complete_flag;
  wire no_home = start_rq & idle & ~home_done; // RULE5
  wire ignored = start_rq & ~idle; // RULE7

  // ----------------------------------------
  // move sequencer
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg              <= ST_IDLE;
      start_d_reg            <= 1'b0;
      move_start             <= 1'b0;
      move_station           <= 8'h00;
      move_table             <= `SPX_TBL_FIRST;
      move_use_speed         <= 1'b0;
      move_speed             <= {SPEED_W{1'b0}};
      move_dir_ccw           <= 1'b0;
      movement_complete_flag <= 1'b1;
    end else begin
      start_d_reg <= s_start;
      move_start  <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (go) begin
            // latch the whole command at the start edge
            move_start             <= 1'b1; // RULE4
            move_station           <= sel_station; // RULE19
            move_table             <= sel_table; // RULE8
            move_use_speed         <= sel_use_spd;
            move_speed             <= s_tsw;
            move_dir_ccw           <= sel_ccw;
            movement_complete_flag <= 1'b0;
            state_reg              <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          // command held until the motion core reports the move finished
          if (motion_done) begin
            movement_complete_flag <= 1'b1; // RULE19
            state_reg              <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // alarm, warning and in-position
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      home_incomplete_alarm <= 1'b0;
      next_station_warning  <= 1'b0;
      in_position_flag      <= 1'b0;
      pwr_chk_reg           <= 1'b1;
      inpos_d_reg           <= 1'b0;
    end else begin
      if (no_home) begin
        home_incomplete_alarm <= 1'b1; // RULE5
      end else if (wr && paddr == `SPX_OFS_CLR && pwdata[`SPX_IRQ_ALARM]) begin
        home_incomplete_alarm <= 1'b0;
      end
      next_station_warning <= mode_on & ~stn_ok(sel_station, div_reg); // RULE6
      pwr_chk_reg          <= 1'b0;
      inpos_d_reg          <= in_position_flag;
      // first check after reset, then at each standstill
      if (pwr_chk_reg) begin
        in_position_flag <= pos_in_range; // RULE11
      end else if (state_reg == ST_MOVE) begin
        in_position_flag <= 1'b0;
      end else begin
        in_position_flag <= pos_in_range;
      end
    end
  end

  // ----------------------------------------
  // standstill torque limit delay
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_cnt_reg        <= 16'h0000;
      tick_cnt_reg       <= 32'h00000000;
      torque_standstill  <= 1'b0;
      torque_limit_value <= 16'hFFFF;
    end else begin
      torque_limit_value <= torque_standstill ? tq_reg : 16'hFFFF;
      if (!in_position_flag) begin
        torque_standstill <= 1'b0;
        dly_cnt_reg       <= 16'h0000;
        tick_cnt_reg      <= 32'h00000000;
      end else if (!inpos_d_reg) begin
        dly_cnt_reg  <= 16'h0000;
        tick_cnt_reg <= 32'h00000000;
      end else if (!torque_standstill) begin
        // count millisecond ticks up to the programmed delay
        if (dly_cnt_reg >= dly_reg) begin
          torque_standstill <= 1'b1; // RULE10
        end else if (tick_cnt_reg >= TICK_CYCLES - 1) begin
          tick_cnt_reg <= 32'h00000000;
          dly_cnt_reg  <= dly_cnt_reg + 16'h0001;
        end else begin
          tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
        end
      end
    end
  end

  // ----------------------------------------
  // interrupt status
  // ----------------------------------------
  wire [3:0] ev;
  assign ev[`SPX_IRQ_ALARM] = no_home;
  assign ev[`SPX_IRQ_WARN]  = start_rq & idle & home_done & ~sel_ok;
  assign ev[`SPX_IRQ_DONE]  = (state_reg == ST_MOVE) & motion_done;
  assign ev[`SPX_IRQ_IGN]   = ignored;

  // an event in the clearing cycle wins over the clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= 4'h0;
      irq      <= 1'b0;
    end else begin
      if (wr && paddr == `SPX_OFS_CLR) begin
        stat_reg <= (stat_reg & ~pwdata[3:0]) | ev;
      end else begin
        stat_reg <= stat_reg | ev;
      end
      irq <= |(stat_reg & en_reg);
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  wire mapped = (paddr == `SPX_OFS_CTRL) || (paddr == `SPX_OFS_DIV) ||
                (paddr == `SPX_OFS_TQ)   || (paddr == `SPX_OFS_DLY) ||
                (paddr == `SPX_OFS_STAT) || (paddr == `SPX_OFS_CLR) ||
                (paddr == `SPX_OFS_EN)   || (paddr == `SPX_OFS_STATE);

  // one wait state, read data and error prepared with pready
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata  <= 32'h00000000;
      if (psel && penable && !pready && !pwrite) begin
        case (paddr)
          `SPX_OFS_CTRL:  prdata <= {28'h0000000, ctrl_reg};
          `SPX_OFS_DIV:   prdata <= {24'h000000, div_reg};
          `SPX_OFS_TQ:    prdata <= {16'h0000, tq_reg};
          `SPX_OFS_DLY:   prdata <= {16'h0000, dly_reg};
          `SPX_OFS_STAT:  prdata <= {28'h0000000, stat_reg};
          `SPX_OFS_EN:    prdata <= {28'h0000000, en_reg};
          `SPX_OFS_STATE: prdata <= {13'h0000, move_table, move_station,
                                     2'h0, next_station_warning, home_incomplete_alarm,
                                     torque_standstill, movement_complete_flag,
                                     in_position_flag, state_reg[1]};
          default:        prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // writable configuration
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SPX_RST_CTRL;
      div_reg  <= `SPX_RST_DIV;
      tq_reg   <= `SPX_RST_TQ;
      dly_reg  <= `SPX_RST_DLY;
      en_reg   <= 4'h0;
    end else if (wr) begin
      case (paddr)
        `SPX_OFS_CTRL: ctrl_reg <= pwdata[3:0];
        `SPX_OFS_DIV:  div_reg  <= pwdata[7:0];
        `SPX_OFS_TQ:   tq_reg   <= pwdata[15:0];
        `SPX_OFS_DLY:  dly_reg  <= pwdata[15:0];
        `SPX_OFS_EN:   en_reg   <= pwdata[3:0];
        default:       en_reg   <= en_reg;
      endcase
    end
  end

endmodule

//--- core/spx_consts.vh
// constants for the shortest-rotation indexer command block
//
// Notes on behaviour
// RULE1 - bit mode: station is the eight selection bits, bit1 least significant, up to 254
// RULE2 - speed table is the three speed bits as binary plus one, tables 1 to 8
// RULE3 - with one link station occupied the speed bits are absent; table 1 is used
// RULE4 - start begins positioning to the selected station with the selected table data
// RULE5 - start before home return completes raises the home-incomplete alarm, no move
// RULE6 - station above division count minus one raises the next-station warning
// RULE7 - starts during a move are ignored; master restarts only after completion flag
// RULE8 - speed bits sampled only at start; changes while rotating do not matter
// RULE9 - master updates station and speed inputs well before start, allowing link delay
// RULE10 - after in-position turns on, torque limit switches to standstill value after delay
// RULE11 - after power-on, in-position is on if position lies within any station range
// RULE12 - the station-numbering direction setting is disregarded in this mode
// RULE13 - mode works only with indexer selected and both mode-select bits on
// RULE14 - with the specifying-system bit on, station comes from the next-station word
// RULE15 - speed method 0: word is a table number; 1: direct speed, ramps of table 1
// RULE16 - direct speed commanding only when two link stations are occupied
// RULE17 - register mode with table speed accepts tables 1 to 7 from the speed word
// RULE18 - rotation direction is chosen automatically for the shortest distance
// RULE19 - station and speed source latch at start and hold until movement completes
`ifndef SPX_CONSTS_VH
`define SPX_CONSTS_VH

// apb register byte offsets
`define SPX_OFS_CTRL    8'h00
`define SPX_OFS_DIV     8'h04
`define SPX_OFS_TQ      8'h08
`define SPX_OFS_DLY     8'h0C
`define SPX_OFS_STAT    8'h10
`define SPX_OFS_CLR     8'h14
`define SPX_OFS_EN      8'h18
`define SPX_OFS_STATE   8'h1C

// control register fields
`define SPX_CTRL_IDX    0
`define SPX_CTRL_TWO    1
`define SPX_CTRL_SPD    2
`define SPX_CTRL_DIR    3

// reset values
`define SPX_RST_CTRL    4'h0
`define SPX_RST_DIV     8'h08
`define SPX_RST_TQ      16'h0000
`define SPX_RST_DLY     16'h0000

// interrupt status bits
`define SPX_IRQ_ALARM   0
`define SPX_IRQ_WARN    1
`define SPX_IRQ_DONE    2
`define SPX_IRQ_IGN     3

// table codes and limits
`define SPX_TBL_FIRST   3'h0
`define SPX_TBL_MAXREG  16'h0007
`define SPX_TBL_MINREG  16'h0001

// torque delay tick, one millisecond, and clock period
`define SPX_TICK_NS     1000000
`define SPX_CLK_NS      25

`endif

//--- dv/spx_indexer_asserts.sv
// assertion checker for the shortest-rotation indexer command block
`timescale 1ns/1ps
module spx_indexer_asserts (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb handshake
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // start link and command
  input wire logic        start_request,
  input wire logic        home_done,
  input wire logic        move_start,
  input wire logic [7:0]  move_station,
  input wire logic [2:0]  move_table,
  input wire logic        movement_complete_flag,
  // torque
  input wire logic        torque_standstill,
  input wire logic [15:0] torque_limit_value
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // apb answer timing
  // ------------------------------------------------------------
  apb_one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after one wait state");
  apb_ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  apb_err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // ------------------------------------------------------------
  // start handshake, command hold and free torque limit
  // ------------------------------------------------------------
  start_pulse_a: assert property (move_start |=> !move_start)
    else $error("move_start longer than one cycle");
  start_cause_a: assert property (move_start |-> $past(start_request, 2) && $past(home_done))
    else $error("move_start without start or home");
  busy_ignore_a: assert property (move_start |-> $past(movement_complete_flag) && !movement_complete_flag)
    else $error("move accepted while busy");
  cmd_hold_a: assert property (!move_start |-> $stable(move_station) && $stable(move_table))
    else $error("latched command changed without start");
  torque_free_a: assert property (!torque_standstill |=> torque_limit_value == 16'hFFFF)
    else $error("torque limit not free while moving");
endmodule

bind spx_indexer spx_indexer_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .start_request(start_request), .home_done(home_done),
  .move_start(move_start), .move_station(move_station), .move_table(move_table),
  .movement_complete_flag(movement_complete_flag), .torque_standstill(torque_standstill),
  .torque_limit_value(torque_limit_value));

//--- dv/spx_motion_model.sv
// motion core model answering move commands promptly or slowly
`timescale 1ns/1ps
module spx_motion_model (
  // clock
  input wire logic        pclk,
  // command from the block
  input wire logic        move_start,
  input wire logic [7:0]  move_station,
  input wire logic        slow,
  // status back to the block
  output logic            motion_done = 1'b0,
  output logic            pos_in_range = 1'b1,
  output logic [7:0]      cur_station = 8'h00
);
  int cnt = 0;
  // run a move, leave the station range, report done on arrival
  always @(posedge pclk) begin
    motion_done <= 1'b0;
    if (move_start) begin
      cnt <= slow ? 40 : 3;
      pos_in_range <= 1'b0;
    end else if (cnt == 1) begin
      cnt <= 0;
      motion_done <= 1'b1;
      pos_in_range <= 1'b1;
      cur_station <= move_station;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

//--- dv/spx_indexer_bench.sv
// self-checking bench for the shortest-rotation indexer command block
`timescale 1ns/1ps
module spx_indexer_bench;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00, nsb = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic        start = 0, m2 = 1, pss = 0, home = 0, slow = 0, es;
  logic [2:0]  spb = 3'h0;
  logic [15:0] nsw = 16'h0, tsw = 16'h0;
  wire  [31:0] prdata;
  wire  [7:0]  cst, mstn;
  wire  [2:0]  mtb;
  wire  [15:0] msp, tqv;
  wire         pready, pslverr, mdone, pinr, mst, ucs, ccw, inp, cmp, alm, wrn, tst, irq;
  int          err_total = 0, checks_done = 0, moves = 0, i;

  spx_indexer #(.TICK_CYCLES(4)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .start_request(start), .op_mode_sel_1(1'b1), .op_mode_sel_2(m2), .pos_speed_spec_select(pss),
    .next_station_sel_bit1(nsb[0]), .next_station_sel_bit2(nsb[1]), .next_station_sel_bit3(nsb[2]),
    .next_station_sel_bit4(nsb[3]), .next_station_sel_bit5(nsb[4]), .next_station_sel_bit6(nsb[5]),
    .next_station_sel_bit7(nsb[6]), .next_station_sel_bit8(nsb[7]), .speed_sel_bit1(spb[0]),
    .speed_sel_bit2(spb[1]), .speed_sel_bit3(spb[2]), .next_station_word(nsw),
    .table_or_speed_word(tsw), .home_done(home), .pos_in_range(pinr), .cur_station(cst),
    .motion_done(mdone), .move_start(mst), .move_station(mstn), .move_table(mtb),
    .move_use_speed(ucs), .move_speed(msp), .move_dir_ccw(ccw), .in_position_flag(inp),
    .movement_complete_flag(cmp), .home_incomplete_alarm(alm), .next_station_warning(wrn),
    .torque_standstill(tst), .torque_limit_value(tqv), .irq(irq));

  spx_motion_model u_motion (.pclk(pclk), .move_start(mst), .move_station(mstn), .slow(slow),
    .motion_done(mdone), .pos_in_range(pinr), .cur_station(cst));

  // clock and accepted-move counter
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (mst === 1'b1) moves++;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // shorter way round eight stations, ties go clockwise
  function automatic logic dirf(logic [7:0] c, logic [7:0] t);
    return ((c - t + 8) % 8) < ((t - c + 8) % 8);
  endfunction

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk("pready", 1, pready);
    rd = prdata;
    es = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  // one start request, plus a second one during a slow move; ok says whether a move must follow
  task automatic go(logic ok, logic [7:0] st, logic [2:0] et, logic eu, logic [15:0] sp);
    int n = 0;
    int m0 = moves;
    logic ed = dirf(cst, st);
    start <= 1;
    while (mst !== 1'b1 && n < 8) begin
      @(posedge pclk);
      n++;
    end
    chk("move_start", ok, mst);
    if (ok) begin
      chk("station", st, mstn);
      chk("table", et, mtb);
      chk("use_speed", eu, ucs);
      if (eu) chk("speed", sp, msp);
      chk("direction", ed, ccw);
      chk("complete_low", 0, cmp);
    end
    repeat (3) @(posedge pclk);
    start <= 0;
    spb <= ~spb;
    if (slow) begin
      repeat (3) @(posedge pclk);
      start <= 1;
      repeat (6) @(posedge pclk);
      start <= 0;
    end
    n = 0;
    while (cmp !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk("complete", 1, cmp);
    chk("moves", m0 + ok, moves);
    @(posedge pclk);
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hBD297498));
    repeat (8) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
    chk("in_position", 1, inp);
    apb(0, 8'h04, 32'h0);
    chk("div_reset", 32'h8, rd);
    apb(0, 8'h24, 32'h0);
    chk("slverr", 1, es);
    apb(1, 8'h18, 32'hF);
    apb(1, 8'h00, 32'hB);
    go(0, 8'h00, 3'h0, 0, 16'h0);
    chk("alarm", 1, alm);
    chk("irq", 1, irq);
    apb(1, 8'h14, 32'hF);
    @(posedge pclk);
    chk("alarm_clr", 0, alm);
    chk("irq_clr", 0, irq);
    home <= 1;
    for (i = 0; i < 8; i++) begin
      nsb <= (i == 0) ? 8'h07 : 8'($urandom % 8);
      spb <= i[2:0];
      slow <= i[0];
      repeat (4) @(posedge pclk);
      go(1, nsb, spb, 0, 16'h0);
    end
    nsb <= 8'h08;
    repeat (4) @(posedge pclk);
    go(0, 8'h00, 3'h0, 0, 16'h0);
    chk("warning", 1, wrn);
    nsb <= 8'h03;
    m2 <= 0;
    repeat (4) @(posedge pclk);
    go(0, 8'h00, 3'h0, 0, 16'h0);
    m2 <= 1;
    pss <= 1;
    for (i = 1; i < 8; i++) begin
      nsw <= 16'(7 - i);
      tsw <= 16'(i);
      repeat (4) @(posedge pclk);
      go(1, nsw[7:0], 3'(i - 1), 0, 16'h0);
    end
    tsw <= 16'h0008;
    repeat (4) @(posedge pclk);
    go(0, 8'h00, 3'h0, 0, 16'h0);
    apb(1, 8'h00, 32'h7);
    tsw <= 16'($urandom);
    nsw <= 16'h0005;
    repeat (4) @(posedge pclk);
    go(1, 8'h05, 3'h0, 1, tsw);
    apb(1, 8'h00, 32'h5);
    tsw <= 16'h0003;
    nsw <= 16'h0001;
    repeat (4) @(posedge pclk);
    go(1, 8'h01, 3'h2, 0, 16'h0);
    apb(1, 8'h00, 32'h1);
    apb(1, 8'h08, 32'h1234);
    pss <= 0;
    nsb <= 8'h02;
    spb <= 3'h5;
    repeat (4) @(posedge pclk);
    go(1, 8'h02, 3'h0, 0, 16'h0);
    repeat (3) @(posedge pclk);
    i = 0;
    while (tst !== 1'b1 && i < 20) begin
      @(posedge pclk);
      i++;
    end
    @(posedge pclk);
    chk("torque", 32'h1234, tqv);
    apb(0, 8'h1C, 32'h0);
    chk("state", 32'h0000020E, rd);
    apb(0, 8'h10, 32'h0);
    chk("status", 32'hE, rd);
    summarize();
  end

  initial begin
    #500000;
    err_total++;
    summarize();
  end
endmodule
